// [src/ucp_pkg.sv]
// ucp_pkg: constants and carrier types for the uart-compatible host port
// assumes a single 125 MHz core clock and an 8-bit host bus
package ucp_pkg;
    // host register addresses
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IEN = 3'h1;
    localparam logic [2:0] ADDR_IID = 3'h2;
    localparam logic [2:0] ADDR_LCTL = 3'h3;
    localparam logic [2:0] ADDR_MCTL = 3'h4;
    localparam logic [2:0] ADDR_LSTAT = 3'h5;
    localparam logic [2:0] ADDR_MSTAT = 3'h6;
    localparam logic [2:0] ADDR_XDIV = 3'h7;
    // reset values
    localparam logic [7:0] IEN_RESET = 8'h00;
    localparam logic [7:0] FCTL_RESET = 8'h00;
    localparam logic [7:0] LCTL_RESET = 8'h00;
    localparam logic [7:0] MCTL_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET = 8'h00;
    // field positions
    localparam int FC_ENABLE = 0;
    localparam int FC_RX_RESET = 1;
    localparam int FC_TX_RESET = 2;
    localparam int LC_DIVSEL = 7;
    localparam int MC_INT_EN = 3;
    // interrupt identifiers (bits 3:1)
    localparam logic [2:0] IID_LINE = 3'h3;
    localparam logic [2:0] IID_TRIG = 3'h2;
    localparam logic [2:0] IID_TMO = 3'h6;
    localparam logic [2:0] IID_TRANSMIT_HOLDING_EMPTY_FLAG = 3'h1;
    localparam logic [2:0] IID_MODEM = 3'h0;
    // fifo geometry and trigger levels
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] TRIG_LVL0 = 5'h01;
    localparam logic [4:0] TRIG_LVL1 = 5'h04;
    localparam logic [4:0] TRIG_LVL2 = 5'h08;
    localparam logic [4:0] TRIG_LVL3 = 5'h0e;
    // receive timeout
    localparam int CLK_MHZ = 125;
    localparam int RX_TMO_US = 4;
    localparam int RX_TMO_CYCLES = RX_TMO_US * CLK_MHZ;

    // host bus request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ucp_host_req_s;

    // micro-controller side byte with its three error flags (break, framing, parity)
    typedef struct packed {
        logic [2:0] err;
        logic [7:0] data;
    } ucp_rx_byte_s;
endpackage

// [src/ucp_byte_fifo.sv]
// ucp_byte_fifo: small synchronous fifo with flush and occupancy count
// assumes one clock; push on full and pop on empty are ignored
module ucp_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    input wire logic pop,
    output logic [WIDTH-1:0] headData,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic doPush;
    logic doPop;

    assign doPush = push && (count != (AW+1)'(DEPTH));
    assign doPop = pop && (count != '0);
    assign headData = mem[rdPtr_q];

    // storage
    always_ff @(posedge clk) begin
        if (doPush) mem[wrPtr_q] <= pushData;
    end

    // pointers and occupancy
    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count <= '0;
        end else begin
            if (doPush) wrPtr_q <= wrPtr_q + AW'(1);
            if (doPop) rdPtr_q <= rdPtr_q + AW'(1);
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule

// [src/ucp_host_port.sv]
// ucp_host_port: host-facing register set of a fifo uart, fed by a micro-controller
// assumes host strobes are one-cycle pulses synchronous to clk
module ucp_host_port
    import ucp_pkg::*;
#(
    parameter int DEPTH = ucp_pkg::FIFO_DEPTH,
    parameter int TMO_CYCLES = ucp_pkg::RX_TMO_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic deviceSelect_n,
    input wire ucp_pkg::ucp_host_req_s hostReq,
    output logic [7:0] hostRdata,
    output logic hostIrq,
    output logic interruptTristateControl_n,
    output logic [2:0] modemCtlOut,
    output logic [7:0] lineControl,
    input wire logic ucRxPush,
    input wire ucp_pkg::ucp_rx_byte_s ucRxByte,
    input wire logic ucStatusWr,
    input wire logic [2:0] ucStatusErr,
    input wire logic ucStopBit,
    input wire logic ucRxTimerEn,
    input wire logic ucTxPop,
    output logic [7:0] ucTxData,
    output logic ucTxValid,
    output logic ucRxReady,
    input wire logic [3:0] modemDelta,
    input wire logic ucMsrRead
);
    import ucp_pkg::*;
    localparam int CW = $clog2(DEPTH) + 1;
    localparam int TW = $clog2(TMO_CYCLES + 1);
    initial begin
        if (DEPTH < 16) $error("fifo depth below highest trigger level");
        if (TMO_CYCLES < 1) $error("timeout must be at least one cycle");
    end

    logic [7:0] ien_q, fctl_q, lctl_q, mctl_q, divLo_q, divHi_q, divX_q, aux_q;
    logic [2:0] errShadow_q;
    logic [2:0] lsErr_q;
    logic overrun_q, transmit_holding_empty_flag_q, txFlushSeen_q, rxFlushSeen_q, modemPend_q, tmo_q, ready_q;
    logic [3:0] iidFrozen_q;
    logic [1:0] iidFifo_q;
    logic iidHold_q;
    logic [TW-1:0] tmoCnt_q;
    logic [CW-1:0] rxCount, txCount;
    ucp_rx_byte_s rxHead;
    logic [7:0] txHead;
    logic rd, wr, divSel, fifoMode;
    logic rdData, wrData, rdLstat, rdIid, rdMstat, wrFctl;
    logic modeChange, rxFlush, txFlush, rxFull, txFull, rxPush;
    logic [4:0] trigLvl;
    logic lineInt, trigInt, tmoInt, thrInt, modemInt;
    logic [3:0] iidLive;
    logic [7:0] rdMux;
    logic errInFifo;
    logic [DEPTH-1:0] errMap_q;

    // decode: one access per strobe, only while selected
    assign rd = hostReq.rd && !deviceSelect_n;
    assign wr = hostReq.wr && !deviceSelect_n;
    assign divSel = lctl_q[LC_DIVSEL];
    assign fifoMode = fctl_q[FC_ENABLE];
    assign rdData = rd && hostReq.addr == ADDR_DATA && !divSel;
    assign wrData = wr && hostReq.addr == ADDR_DATA && !divSel;
    assign rdLstat = rd && hostReq.addr == ADDR_LSTAT;
    assign rdIid = rd && hostReq.addr == ADDR_IID;
    assign rdMstat = rd && hostReq.addr == ADDR_MSTAT;
    assign wrFctl = wr && hostReq.addr == ADDR_IID;

    // fifo control effects: mode change and self-clearing resets
    assign modeChange = wrFctl && (hostReq.wdata[FC_ENABLE] != fctl_q[FC_ENABLE]);
    assign rxFlush = modeChange || (wrFctl && hostReq.wdata[FC_ENABLE]
        && hostReq.wdata[FC_RX_RESET]);
    assign txFlush = modeChange || (wrFctl && hostReq.wdata[FC_ENABLE]
        && hostReq.wdata[FC_TX_RESET]);

    // single-byte mode holds one byte, fifo mode the full depth
    assign rxFull = fifoMode ? (rxCount == CW'(DEPTH)) : (rxCount != '0);
    assign txFull = fifoMode ? (txCount == CW'(DEPTH)) : (txCount != '0);
    assign rxPush = ucRxPush && !rxFull;

    ucp_byte_fifo #(.WIDTH(11), .DEPTH(DEPTH)) rxFifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .flush(rxFlush),
        .push(rxPush),
        .pushData({errShadow_q | ucRxByte.err, ucRxByte.data}),
        .pop(rdData),
        .headData(rxHead),
        .count(rxCount)
    );

    ucp_byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txFifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .flush(txFlush),
        .push(wrData && !txFull),
        .pushData(hostReq.wdata),
        .pop(ucTxPop),
        .headData(txHead),
        .count(txCount)
    );

    // per-slot error map mirrors the rx fifo for the data-error summary
    always_ff @(posedge clk) begin
        if (sys_rst || rxFlush) begin
            errMap_q <= '0;
        end else begin
            errMap_q <= (errMap_q >> (rdData && rxCount != '0))
                | (DEPTH'(rxPush && (errShadow_q | ucRxByte.err) != 3'h0)
                << (rxCount - CW'(rdData && rxCount != '0)));
        end
    end
    assign errInFifo = |errMap_q;

    // trigger level table
    always_comb begin
        case (fctl_q[7:6])
            2'h0: trigLvl = TRIG_LVL0;
            2'h1: trigLvl = TRIG_LVL1;
            2'h2: trigLvl = TRIG_LVL2;
            default: trigLvl = TRIG_LVL3;
        endcase
    end

    // host-written control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ien_q <= IEN_RESET;
            fctl_q <= FCTL_RESET;
            lctl_q <= LCTL_RESET;
            mctl_q <= MCTL_RESET;
            divLo_q <= DIV_RESET;
            divHi_q <= DIV_RESET;
            divX_q <= DIV_RESET;
            aux_q <= DIV_RESET;
        end else if (wr) begin
            case (hostReq.addr)
                ADDR_DATA: if (divSel) divLo_q <= hostReq.wdata;
                ADDR_IEN: begin
                    if (divSel) divHi_q <= hostReq.wdata;
                    else ien_q <= {4'h0, hostReq.wdata[3:0]};
                end
                ADDR_IID: begin
                    if (hostReq.wdata[FC_ENABLE]) begin
                        fctl_q <= {hostReq.wdata[7:3], 2'h0, 1'b1};
                    end else begin
                        fctl_q[FC_ENABLE] <= 1'b0;
                    end
                end
                ADDR_LCTL: lctl_q <= hostReq.wdata;
                ADDR_MCTL: begin
                    if (divSel) aux_q <= hostReq.wdata;
                    else mctl_q <= {3'h0, hostReq.wdata[4:0]};
                end
                ADDR_XDIV: if (divSel) divX_q <= hostReq.wdata;
                default: ;
            endcase
        end
    end

    // fifo reset shadows, held until the host reads fifo status
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txFlushSeen_q <= 1'b0;
            rxFlushSeen_q <= 1'b0;
        end else begin
            if (txFlush && wrFctl && hostReq.wdata[FC_TX_RESET]) txFlushSeen_q <= 1'b1;
            else if (rdIid) txFlushSeen_q <= 1'b0;
            if (rxFlush && wrFctl && hostReq.wdata[FC_RX_RESET]) rxFlushSeen_q <= 1'b1;
            else if (rdIid) rxFlushSeen_q <= 1'b0;
        end
    end

    // error shadow from the controller, consumed by the next controller push, stored or dropped
    always_ff @(posedge clk) begin
        if (sys_rst || modeChange) begin
            errShadow_q <= 3'h0;
        end else if (ucStatusWr) begin
            errShadow_q <= ucStatusErr;
        end else if (ucRxPush) begin
            errShadow_q <= 3'h0;
        end
    end

    // line status error and overrun bits; events win over the clearing read
    always_ff @(posedge clk) begin
        if (sys_rst || modeChange) begin
            lsErr_q <= 3'h0;
            overrun_q <= 1'b0;
        end else begin
            if (rdData && rxCount != '0) lsErr_q <= rxHead.err;
            else if (rdLstat) lsErr_q <= 3'h0;
            if (ucRxPush && rxFull) overrun_q <= 1'b1;
            else if (rdLstat) overrun_q <= 1'b0;
        end
    end

    // transmit holding empty flag
    always_ff @(posedge clk) begin
        if (sys_rst || modeChange) begin
            transmit_holding_empty_flag_q <= 1'b1;
        end else if (txCount == CW'(1) && ucTxPop) begin
            transmit_holding_empty_flag_q <= 1'b1;
        end else if (fifoMode ? (txCount >= CW'(trigLvl)) : wrData) begin
            transmit_holding_empty_flag_q <= 1'b0;
        end
    end

    // transmit-empty interrupt: armed on empty, disarmed by write or ident read
    logic thrPend_q;
    always_ff @(posedge clk) begin
        if (sys_rst || modeChange) begin
            thrPend_q <= 1'b1;
        end else if (txCount == CW'(1) && ucTxPop) begin
            thrPend_q <= 1'b1;
        end else if (wrData || (rdIid && iidFrozen_q[3:1] == IID_TRANSMIT_HOLDING_EMPTY_FLAG && !iidFrozen_q[0])) begin
            thrPend_q <= 1'b0;
        end
    end

    // modem delta pending, cleared by a modem status read
    always_ff @(posedge clk) begin
        if (sys_rst || modeChange) modemPend_q <= 1'b0;
        else if (|modemDelta) modemPend_q <= 1'b1;
        else if (rdMstat || ucMsrRead) modemPend_q <= 1'b0;
    end

    // receive timeout counter and data-ready delay
    always_ff @(posedge clk) begin
        if (sys_rst || rxFlush || rxCount == '0) begin
            tmoCnt_q <= '0;
            tmo_q <= 1'b0;
            ready_q <= 1'b0;
        end else if (rdData || ucStopBit || rxPush) begin
            tmoCnt_q <= '0;
            tmo_q <= rdData ? 1'b0 : tmo_q;
            ready_q <= ready_q || !ucRxTimerEn;
        end else if (tmoCnt_q == TW'(TMO_CYCLES)) begin
            tmo_q <= 1'b1;
            ready_q <= 1'b1;
        end else begin
            tmoCnt_q <= tmoCnt_q + TW'(1);
            ready_q <= ready_q || !ucRxTimerEn;
        end
    end

    // interrupt sources and priority
    assign lineInt = ien_q[2] && (overrun_q || lsErr_q != 3'h0);
    assign trigInt = ien_q[0] && (fifoMode ? (rxCount >= CW'(trigLvl)) : ready_q);
    assign tmoInt = ien_q[0] && tmo_q;
    assign thrInt = ien_q[1] && thrPend_q && transmit_holding_empty_flag_q;
    assign modemInt = ien_q[3] && modemPend_q;

    always_comb begin
        if (lineInt) iidLive = {IID_LINE, 1'b0};
        else if (trigInt) iidLive = {IID_TRIG, 1'b0};
        else if (tmoInt) iidLive = {IID_TMO, 1'b0};
        else if (thrInt) iidLive = {IID_TRANSMIT_HOLDING_EMPTY_FLAG, 1'b0};
        else if (modemInt) iidLive = {IID_MODEM, 1'b0};
        else iidLive = 4'h1;
    end

    // identification snapshot, frozen while the host read is in progress
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            iidFrozen_q <= 4'h1;
            iidFifo_q <= 2'h0;
            iidHold_q <= 1'b0;
        end else begin
            iidHold_q <= rdIid;
            if (!rdIid && !iidHold_q) begin
                iidFrozen_q <= iidLive;
                iidFifo_q <= {2{fifoMode && !fctl_q[3]}};
            end
        end
    end

    // read data multiplexer
    always_comb begin
        rdMux = 8'h00;
        case (hostReq.addr)
            ADDR_DATA: rdMux = divSel ? divLo_q : rxHead.data;
            ADDR_IEN: rdMux = divSel ? divHi_q : {4'h0, ien_q[3:0]};
            ADDR_IID: rdMux = {iidFifo_q, 2'h0, iidFrozen_q};
            ADDR_LCTL: rdMux = lctl_q;
            ADDR_MCTL: rdMux = divSel ? aux_q : mctl_q;
            ADDR_LSTAT: rdMux = {errInFifo, transmit_holding_empty_flag_q, transmit_holding_empty_flag_q, lsErr_q, overrun_q, ready_q};
            ADDR_XDIV: rdMux = divSel ? divX_q : 8'h00;
            default: rdMux = 8'h00;
        endcase
    end

    // registered outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hostRdata <= 8'h00;
            hostIrq <= 1'b0;
            interruptTristateControl_n <= 1'b0;
            modemCtlOut <= 3'h0;
            lineControl <= LCTL_RESET;
            ucTxData <= 8'h00;
            ucTxValid <= 1'b0;
            ucRxReady <= 1'b0;
        end else begin
            if (rd) hostRdata <= rdMux;
            hostIrq <= !iidLive[0];
            interruptTristateControl_n <= mctl_q[MC_INT_EN];
            modemCtlOut <= mctl_q[2:0];
            lineControl <= lctl_q;
            ucTxData <= txHead;
            ucTxValid <= txCount != '0 && !(ucTxPop && txCount == CW'(1));
            ucRxReady <= rxCount != '0;
        end
    end
endmodule

// [tb/ucp_host_port_checker.sv]
// ucp_host_port_checker: pin-level timing relations of the host port
// assumes it is bound to ucp_host_port and host strobes last one cycle
module ucp_host_port_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic deviceSelect_n,
    input wire ucp_pkg::ucp_host_req_s hostReq,
    input wire logic [7:0] hostRdata,
    input wire logic interruptTristateControl_n,
    input wire logic [2:0] modemCtlOut,
    input wire logic [7:0] lineControl,
    input wire logic ucRxPush,
    input wire logic ucTxValid,
    input wire logic ucRxReady
);
    timeunit 1ns;
    timeprecision 1ps;
    import ucp_pkg::*;
    logic hWr;
    logic hRd;
    logic divSel;
    // strobes that the port accepts
    assign hWr = hostReq.wr && !deviceSelect_n;
    assign hRd = hostReq.rd && !deviceSelect_n;
    assign divSel = lineControl[LC_DIVSEL];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_tristate_follows: assert property (hWr && hostReq.addr == ADDR_MCTL && !divSel
        |-> ##2 interruptTristateControl_n == $past(hostReq.wdata[MC_INT_EN], 2))
        else $error("tristate control does not follow modem control bit 3");
    a_aux_hidden: assert property (hWr && hostReq.addr == ADDR_MCTL && divSel
        |=> $stable(modemCtlOut))
        else $error("modem control changed while divisor select set");
    a_lctl_load: assert property (hWr && hostReq.addr == ADDR_LCTL
        |-> ##2 lineControl == $past(hostReq.wdata, 2))
        else $error("line control not loaded by host write");
    a_deselect_ignored: assert property (hostReq.wr && deviceSelect_n
        |-> ##2 $stable(lineControl))
        else $error("write accepted while device not selected");
    a_rdata_holds: assert property (!hRd |=> $stable(hostRdata))
        else $error("read data changed without a read strobe");
    a_ien_upper: assert property (hRd && hostReq.addr == ADDR_IEN && !divSel
        |=> hostRdata[7:4] == 4'h0)
        else $error("interrupt enable upper bits not zero");
    a_ident_reserved: assert property (hRd && hostReq.addr == ADDR_IID
        |-> ##1 hostRdata[5:4] == 2'h0)
        else $error("ident bits 5:4 not zero");
    a_ready_shadow: assert property (ucRxPush |-> ##[1:2] ucRxReady)
        else $error("undelayed data ready missing after store");
    a_tx_loaded: assert property (hWr && hostReq.addr == ADDR_DATA && !divSel
        |-> ##[1:2] ucTxValid)
        else $error("transmit byte not offered after host write");
    a_tx_flush: assert property (hWr && hostReq.addr == ADDR_IID
        && hostReq.wdata[FC_ENABLE] && hostReq.wdata[FC_TX_RESET]
        |-> ##[1:2] !ucTxValid)
        else $error("transmit data survives a transmit reset");
endmodule

bind ucp_host_port ucp_host_port_checker chk_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .deviceSelect_n(deviceSelect_n),
    .hostReq(hostReq),
    .hostRdata(hostRdata),
    .interruptTristateControl_n(interruptTristateControl_n),
    .modemCtlOut(modemCtlOut),
    .lineControl(lineControl),
    .ucRxPush(ucRxPush),
    .ucTxValid(ucTxValid),
    .ucRxReady(ucRxReady)
);

// [tb/ucp_host_model.sv]
// ucp_host_model: host processor on the 8-bit parallel register bus
// assumes strobes are launched at the falling edge and last one cycle
module ucp_host_model (
    input wire logic clk,
    output logic deviceSelect_n,
    output ucp_pkg::ucp_host_req_s hostReq,
    input wire logic [7:0] hostRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import ucp_pkg::*;
    // bus idle and selected at time zero
    initial begin
        deviceSelect_n = 1'b0;
        hostReq = '0;
    end
    // one bus cycle; released data lines show the inverted last value
    task automatic cyc(input logic rd, input logic [2:0] a, input logic [7:0] d,
                       input logic selN, output logic [7:0] q);
        @(negedge clk);
        deviceSelect_n = selN;
        hostReq = '{rd: rd, wr: !rd, addr: a, wdata: d};
        if (!rd && a == ADDR_IID) begin
            hostReq.wdata[3] = 1'b0;
        end
        @(negedge clk);
        hostReq.rd = 1'b0;
        hostReq.wr = 1'b0;
        hostReq.wdata = ~hostReq.wdata;
        deviceSelect_n = 1'b0;
        q = hostRdata;
    endtask
endmodule

// [tb/testbench.sv]
// testbench: register, interrupt and fifo checks of the host port
// assumes ucp_host_model as host and the bound pin checker
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ucp_pkg::*;
    typedef struct packed {
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } ucp_row_s;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic deviceSelect_n;
    ucp_host_req_s hostReq;
    logic [7:0] hostRdata;
    logic hostIrq;
    logic triN;
    logic [2:0] modemCtlOut;
    logic [7:0] lineControl;
    logic ucRxPush = 1'b0;
    ucp_rx_byte_s ucRxByte = '0;
    logic ucStatusWr = 1'b0;
    logic [2:0] ucStatusErr = 3'h0;
    logic ucStopBit = 1'b0;
    logic ucTxPop = 1'b0;
    logic ucRxTimerEn = 1'b0;
    logic [3:0] modemDelta = 4'h0;
    logic [7:0] ucTxData;
    logic ucTxValid;
    logic ucRxReady;
    int failures = 0;
    int checks = 0;
    ucp_row_s rows[6] = '{'{ADDR_IEN, 8'hff, 8'h0f}, '{ADDR_LCTL, 8'h3b, 8'h3b},
        '{ADDR_MCTL, 8'h07, 8'h07}, '{ADDR_IEN, 8'h00, 8'h00},
        '{ADDR_MCTL, 8'h08, 8'h08}, '{ADDR_LCTL, 8'h00, 8'h00}};
    logic [4:0] lv[4] = '{TRIG_LVL0, TRIG_LVL1, TRIG_LVL2, TRIG_LVL3};
    // 125 MHz core clock
    initial begin
        forever #4 clk = ~clk;
    end
    ucp_host_model host_u (.clk(clk), .deviceSelect_n(deviceSelect_n),
        .hostReq(hostReq), .hostRdata(hostRdata));
    ucp_host_port #(.TMO_CYCLES(100)) dut_u (.clk(clk), .sys_rst(sys_rst),
        .deviceSelect_n(deviceSelect_n), .hostReq(hostReq), .hostRdata(hostRdata),
        .hostIrq(hostIrq), .interruptTristateControl_n(triN),
        .modemCtlOut(modemCtlOut), .lineControl(lineControl), .ucRxPush(ucRxPush),
        .ucRxByte(ucRxByte), .ucStatusWr(ucStatusWr), .ucStatusErr(ucStatusErr),
        .ucStopBit(ucStopBit), .ucRxTimerEn(ucRxTimerEn), .ucTxPop(ucTxPop),
        .ucTxData(ucTxData), .ucTxValid(ucTxValid), .ucRxReady(ucRxReady),
        .modemDelta(modemDelta), .ucMsrRead(1'b0));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] q;
        host_u.cyc(1'b1, a, 8'h00, 1'b0, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        host_u.cyc(1'b0, a, d, 1'b0, q);
    endtask
    // controller stores one byte at a stop bit centre
    task automatic push(input logic [2:0] e, input logic [7:0] d);
        @(negedge clk);
        ucRxPush = 1'b1;
        ucStopBit = 1'b1;
        ucRxByte = '{err: e, data: d};
        @(negedge clk);
        ucRxPush = 1'b0;
        ucStopBit = 1'b0;
        ucRxByte = ~ucRxByte;
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end
    // main sequence
    initial begin
        logic [7:0] q;
        repeat (10) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        rd(ADDR_IEN, 8'h00);
        rd(ADDR_LSTAT, 8'h60);
        rd(ADDR_IID, 8'h01);
        chk({7'h0, triN}, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        chk({7'h0, triN}, 8'h01);
        // transmit empty interrupt and its clearing by ident read
        wr(ADDR_IEN, 8'h02);
        repeat (2) @(negedge clk);
        chk({7'h0, hostIrq}, 8'h01);
        rd(ADDR_IID, 8'h02);
        // ident stays frozen for the cycle after a read
        @(negedge clk);
        rd(ADDR_IID, 8'h01);
        chk({7'h0, hostIrq}, 8'h00);
        // per-byte errors and line status interrupt
        wr(ADDR_IEN, 8'h04);
        push(3'h5, 8'ha5);
        rd(ADDR_LSTAT, 8'he1);
        rd(ADDR_DATA, 8'ha5);
        rd(ADDR_IID, 8'h06);
        rd(ADDR_LSTAT, 8'h74);
        rd(ADDR_IID, 8'h01);
        // shadow error then overrun in single-byte mode
        @(negedge clk);
        ucStatusWr = 1'b1;
        ucStatusErr = 3'h2;
        @(negedge clk);
        ucStatusWr = 1'b0;
        push(3'h0, 8'h11);
        push(3'h0, 8'h22);
        rd(ADDR_LSTAT, 8'he3);
        rd(ADDR_LSTAT, 8'he1);
        rd(ADDR_DATA, 8'h11);
        rd(ADDR_LSTAT, 8'h68);
        // transmit holding write and drain
        wr(ADDR_DATA, 8'h3c);
        @(negedge clk);
        chk(ucTxData, 8'h3c);
        chk({7'h0, ucTxValid}, 8'h01);
        rd(ADDR_LSTAT, 8'h00);
        @(negedge clk);
        ucTxPop = 1'b1;
        @(negedge clk);
        ucTxPop = 1'b0;
        chk({7'h0, ucTxValid}, 8'h00);
        rd(ADDR_LSTAT, 8'h60);
        // every trigger level in fifo mode
        wr(ADDR_IEN, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_IID, {i[1:0], 6'h07});
            for (int j = 1; j < int'(lv[i]); j++) begin
                push(3'h0, 8'(j));
            end
            rd(ADDR_IID, 8'hc1);
            push(3'h0, {3'h0, lv[i]});
            rd(ADDR_IID, 8'hc4);
        end
        // drop below the trigger so the timeout becomes the reported source
        rd(ADDR_DATA, 8'h01);
        rd(ADDR_IID, 8'hc1);
        repeat (120) @(negedge clk);
        rd(ADDR_IID, 8'hcc);
        rd(ADDR_DATA, 8'h02);
        rd(ADDR_IID, 8'hc1);
        wr(ADDR_IID, 8'h07);
        repeat (120) @(negedge clk);
        rd(ADDR_IID, 8'hc1);
        rd(ADDR_LSTAT, 8'h60);
        wr(ADDR_IID, 8'h00);
        rd(ADDR_IID, 8'h01);
        // divisor select hides the general registers
        wr(ADDR_LCTL, 8'h80);
        wr(ADDR_IEN, 8'h5a);
        wr(ADDR_MCTL, 8'h0f);
        rd(ADDR_IEN, 8'h5a);
        wr(ADDR_LCTL, 8'h00);
        rd(ADDR_IEN, 8'h01);
        chk({5'h0, modemCtlOut}, 8'h00);
        // modem delta interrupt, cleared by a modem status read
        wr(ADDR_IEN, 8'h08);
        @(negedge clk);
        modemDelta = 4'h4;
        @(negedge clk);
        modemDelta = 4'h0;
        rd(ADDR_IID, 8'h00);
        chk({7'h0, hostIrq}, 8'h01);
        rd(ADDR_MSTAT, 8'h00);
        rd(ADDR_IID, 8'h01);
        chk({7'h0, hostIrq}, 8'h00);
        // receive timer delays host data ready but not the controller shadow
        ucRxTimerEn = 1'b1;
        push(3'h0, 8'h5c);
        @(negedge clk);
        chk({7'h0, ucRxReady}, 8'h01);
        rd(ADDR_LSTAT, 8'h60);
        repeat (120) @(negedge clk);
        rd(ADDR_LSTAT, 8'h61);
        rd(ADDR_DATA, 8'h5c);
        ucRxTimerEn = 1'b0;
        // write while not selected
        host_u.cyc(1'b0, ADDR_LCTL, 8'h3f, 1'b1, q);
        rd(ADDR_LCTL, 8'h00);
        close_out();
    end
endmodule
